/* File: rtl/ascii_can_command_parser.sv */
// ASCII command interpreter between a host byte link and the CAN engine.
`timescale 1ns/10ps
`include "cmd_parser_consts.svh"
module ascii_can_command_parser (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire cmd_parser_pkg::byte_type rx_byte,
	output logic                        rx_ready,
	output cmd_parser_pkg::byte_type    tx_byte,
	input  wire logic                   tx_ready,
	output logic                        cmd_start,
	output logic [7:0]                  cmd_letter,
	input  wire logic                   cmd_done,
	input  wire logic                   cmd_ok,
	input  wire cmd_parser_pkg::byte_type can_byte,
	output logic                        can_ready,
	input  wire logic                   can_msg_end
);
	cmd_parser_pkg::state_type state_r, state_nxt;
	logic [7:0] letter_r;
	logic [4:0] len_r;
	logic [7:0] reply_r;
	logic [7:0] help_idx_r;
	logic       in_msg_r;
	logic [7:0] help_rom [0:63];

	function automatic logic known_letter(input logic [7:0] c);
		case (c)
			8'h4F, 8'h43, 8'h74, 8'h54, 8'h46, 8'h56, 8'h4E, 8'h5A,
			8'h53, 8'h73, 8'h6D, 8'h4D, 8'h42, 8'h4C, 8'h45, 8'h52: known_letter = 1'b1;
			default: known_letter = 1'b0;
		endcase
	endfunction : known_letter

	// Help listing: the command letters, each followed by CR, then CR padding up to HELP_LEN bytes; the last CR answers OK.
	initial begin
		for (int i = 0; i < 64; i++) begin
			help_rom[i] = `CHR_CR;
		end
		help_rom[0] = 8'h4F;
		help_rom[2] = 8'h43;
		help_rom[4] = 8'h74;
		help_rom[6] = 8'h54;
		help_rom[8] = 8'h46;
		help_rom[10] = 8'h56;
		help_rom[12] = 8'h4E;
		help_rom[14] = 8'h5A;
		help_rom[16] = 8'h53;
		help_rom[18] = 8'h73;
		help_rom[20] = 8'h6D;
		help_rom[22] = 8'h4D;
		help_rom[24] = 8'h42;
		help_rom[26] = 8'h4C;
		help_rom[28] = 8'h45;
		help_rom[30] = 8'h52;
		help_rom[32] = 8'h48;
		help_rom[34] = 8'h3F;
		help_rom[36] = 8'h68;
	end

	wire is_cr    = rx_byte.valid && rx_byte.data == `CHR_CR;
	wire is_help  = letter_r == `CHR_UP_H || letter_r == `CHR_LO_H || letter_r == `CHR_QMARK;
	wire is_known = known_letter(letter_r);
	wire collect  = state_r == cmd_parser_pkg::ST_COLLECT;
	wire fwd_sel  = in_msg_r || (collect && can_byte.valid && !rx_byte.valid);

	// A CAN message in progress owns the link until its last byte, so replies never split it.
	assign can_ready = fwd_sel && tx_ready;
	assign rx_ready  = collect && !in_msg_r;
	assign cmd_start = state_r == cmd_parser_pkg::ST_DISPATCH && is_known && !is_help;
	assign cmd_letter = letter_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cmd_parser_pkg::ST_COLLECT: begin
				if (is_cr && !in_msg_r) begin
					state_nxt = cmd_parser_pkg::ST_DISPATCH;
				end
			end
			cmd_parser_pkg::ST_DISPATCH: begin
				if (is_help) begin
					state_nxt = cmd_parser_pkg::ST_HELP;
				end else if (is_known) begin
					state_nxt = cmd_parser_pkg::ST_EXEC;
				end else begin
					state_nxt = cmd_parser_pkg::ST_REPLY;
				end
			end
			cmd_parser_pkg::ST_EXEC: begin
				if (cmd_done) begin
					state_nxt = cmd_parser_pkg::ST_REPLY;
				end
			end
			cmd_parser_pkg::ST_REPLY: begin
				if (tx_ready) begin
					state_nxt = cmd_parser_pkg::ST_COLLECT;
				end
			end
			cmd_parser_pkg::ST_HELP: begin
				if (tx_ready && help_idx_r == `HELP_LEN - 8'h01) begin
					state_nxt = cmd_parser_pkg::ST_COLLECT;
				end
			end
			default: state_nxt = cmd_parser_pkg::ST_COLLECT;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= cmd_parser_pkg::ST_COLLECT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The first byte after CR is the command letter; overlong lines are bounded by len_r.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			letter_r <= 8'h00;
			len_r    <= 5'h00;
		end else if (rx_ready && rx_byte.valid) begin
			if (is_cr) begin
				len_r <= 5'h00;
				// A bare CR must not replay the letter of the line before it.
				if (len_r == 5'h00) begin
					letter_r <= 8'h00;
				end
			end else if (len_r != `LINE_MAX) begin
				len_r <= len_r + 5'h01;
				if (len_r == 5'h00) begin
					letter_r <= rx_byte.data;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reply_r <= `CHR_CR;
		end else if (state_r == cmd_parser_pkg::ST_DISPATCH) begin
			reply_r <= `CHR_BELL;
		end else if (state_r == cmd_parser_pkg::ST_EXEC && cmd_done) begin
			reply_r <= cmd_ok ? `CHR_CR : `CHR_BELL;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			help_idx_r <= 8'h00;
		end else if (state_r != cmd_parser_pkg::ST_HELP) begin
			help_idx_r <= 8'h00;
		end else if (tx_ready) begin
			help_idx_r <= help_idx_r + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_msg_r <= 1'b0;
		end else if (can_ready && can_byte.valid) begin
			in_msg_r <= !can_msg_end;
		end
	end

	// Transmit data is only replies, help text or CAN bytes; host bytes never reach it.
	always_comb begin
		tx_byte = '0;
		if (fwd_sel) begin
			tx_byte = can_byte;
		end else if (state_r == cmd_parser_pkg::ST_REPLY) begin
			tx_byte.valid = 1'b1;
			tx_byte.data  = reply_r;
		end else if (state_r == cmd_parser_pkg::ST_HELP) begin
			tx_byte.valid = 1'b1;
			tx_byte.data  = help_rom[help_idx_r[5:0]];
		end
	end

	sequence unknown_cmd_s;
		state_r == cmd_parser_pkg::ST_DISPATCH && !is_known && !is_help;
	endsequence

	sequence empty_line_s;
		collect && is_cr && !in_msg_r && len_r == 5'h00;
	endsequence

	sequence reply_wait_s;
		state_r == cmd_parser_pkg::ST_REPLY && !tx_ready;
	endsequence

	unknown_bell_a: assert property (@(posedge clk) disable iff (!nrst)
		unknown_cmd_s |=> tx_byte.data == `CHR_BELL && !cmd_start)
		else $error("Unknown command did not answer bell.");
	no_echo_a: assert property (@(posedge clk) disable iff (!nrst)
		(rx_byte.valid && tx_byte.valid && !fwd_sel) |-> state_r != cmd_parser_pkg::ST_COLLECT)
		else $error("Host byte appeared on the host-bound stream.");
	can_fwd_a: assert property (@(posedge clk) disable iff (!nrst)
		(collect && can_byte.valid && !rx_byte.valid && tx_ready) |-> can_ready)
		else $error("CAN byte was not forwarded.");
	msg_whole_a: assert property (@(posedge clk) disable iff (!nrst)
		in_msg_r |-> !tx_byte.valid || tx_byte == can_byte)
		else $error("Reply split a CAN message.");
	help_list_a: assert property (@(posedge clk) disable iff (!nrst)
		(state_r == cmd_parser_pkg::ST_DISPATCH && is_help) |=> state_r == cmd_parser_pkg::ST_HELP)
		else $error("Help request did not start the listing.");
	known_start_a: assert property (@(posedge clk) disable iff (!nrst)
		(state_r == cmd_parser_pkg::ST_DISPATCH && is_known) |-> cmd_start ##1 state_r == cmd_parser_pkg::ST_EXEC)
		else $error("Known command was not started.");
	reply_code_a: assert property (@(posedge clk) disable iff (!nrst)
		(state_r == cmd_parser_pkg::ST_EXEC && cmd_done) |=> tx_byte.data == ($past(cmd_ok) ? `CHR_CR : `CHR_BELL))
		else $error("Reply code does not match the result.");
	one_at_time_a: assert property (@(posedge clk) disable iff (!nrst)
		!collect |-> !rx_ready)
		else $error("Host bytes taken while a command runs.");
	empty_line_a: assert property (@(posedge clk) disable iff (!nrst)
		empty_line_s |=> state_r == cmd_parser_pkg::ST_DISPATCH && !cmd_start)
		else $error("Empty line started a command.");
	reply_stands_a: assert property (@(posedge clk) disable iff (!nrst)
		reply_wait_s |=> state_r == cmd_parser_pkg::ST_REPLY && tx_byte.valid)
		else $error("Reply withdrawn before the host took it.");
	line_end_a: assert property (@(posedge clk) disable iff (!nrst)
		(collect && is_cr && !in_msg_r) |=> state_r == cmd_parser_pkg::ST_DISPATCH)
		else $error("Carriage return did not dispatch the line.");
	help_first_a: assert property (@(posedge clk) disable iff (!nrst)
		(state_r == cmd_parser_pkg::ST_DISPATCH && is_help) |=> tx_byte.valid && known_letter(tx_byte.data))
		else $error("Help listing did not open with a command letter.");
endmodule : ascii_can_command_parser

/* File: common/cmd_parser_consts.svh */
// Constants of the ASCII command interpreter.
// How it works
// - Unknown command letter answers bell only
// - Received command bytes are never echoed back
// - CAN messages forwarded unasked, while collecting a line and no host byte is offered
// - Keep up with 50us-spaced bursts of messages
// - H, h or ? returns the help listing
// - Recognize the defined set of command letters
// - Success answers carriage return, failure bell
`ifndef CMD_PARSER_CONSTS_SVH
`define CMD_PARSER_CONSTS_SVH
`define CHR_CR       8'h0D
`define CHR_BELL     8'h07
`define CHR_QMARK    8'h3F
`define CHR_UP_H     8'h48
`define CHR_LO_H     8'h68
`define CLK_HZ       20000000
`define BURST_NS     50000
`define BURST_CYC    ((`CLK_HZ / 1000) * (`BURST_NS / 1000) / 1000)
`define LINE_MAX     5'h1F
`define HELP_LEN     8'h3C
`endif

/* File: common/cmd_parser_pkg.sv */
// Types of the ASCII command interpreter.
package cmd_parser_pkg;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_type;
	typedef enum logic [2:0] {
		ST_COLLECT = 3'b000,
		ST_DISPATCH = 3'b001,
		ST_EXEC = 3'b011,
		ST_REPLY = 3'b010,
		ST_HELP = 3'b110,
		ST_FWD = 3'b111
	} state_type;
	typedef enum logic [1:0] {
		RES_OK = 2'h0,
		RES_FAIL = 2'h1,
		RES_HELP = 2'h2,
		RES_UNKNOWN = 2'h3
	} result_type;
endpackage : cmd_parser_pkg

/* File: test/host_link_model.sv */
// Host side of the byte link: sinks every byte the interpreter sends.
`timescale 1ns/10ps
module host_link_model (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire cmd_parser_pkg::byte_type tx_byte,
	input  wire logic                     slow,
	output logic                          tx_ready
);
	logic        ph_r;
	logic [7:0]  last_byte;
	int unsigned got = 0;
	// A slow host accepts only every other cycle, so replies must stand until taken.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) ph_r <= 1'b0;
		else ph_r <= ~ph_r;
	end
	assign tx_ready = !slow || ph_r;
	always @(posedge clk) begin
		if (tx_byte.valid === 1'b1 && tx_ready) begin
			got <= got + 1;
			last_byte <= tx_byte.data;
		end
	end
endmodule : host_link_model

/* File: test/ascii_can_command_parser_tb_top.sv */
// Self-checking bench of the ASCII command interpreter.
`timescale 1ns/10ps
`include "cmd_parser_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, (a), (e)); end end
module ascii_can_command_parser_tb_top;
	typedef struct packed {logic [7:0] l; logic ok; logic [7:0] last; logic [7:0] cnt; logic st;} row_type;
	logic                     clk, nrst, tx_ready, rx_ready, cmd_start, cmd_done, cmd_ok, can_ready, can_msg_end, slow;
	logic [7:0]               cmd_letter;
	cmd_parser_pkg::byte_type rx_byte, tx_byte, can_byte;
	int                       err_total = 0;
	int                       total_checks = 0;
	string                    letters = "OCtTFVNZSsmMBLER";
	row_type rows [8] = '{'{8'h58, 1'b0, `CHR_BELL, 8'h01, 1'b0}, '{8'h61, 1'b0, `CHR_BELL, 8'h01, 1'b0},
		'{8'h4F, 1'b1, `CHR_CR, 8'h01, 1'b1}, '{8'h43, 1'b0, `CHR_BELL, 8'h01, 1'b1},
		'{`CHR_UP_H, 1'b0, `CHR_CR, `HELP_LEN, 1'b0}, '{`CHR_LO_H, 1'b0, `CHR_CR, `HELP_LEN, 1'b0},
		'{`CHR_QMARK, 1'b0, `CHR_CR, `HELP_LEN, 1'b0}, '{`CHR_CR, 1'b0, `CHR_BELL, 8'h02, 1'b0}};
	ascii_can_command_parser i_ascii_can_command_parser (.clk(clk), .nrst(nrst), .rx_byte(rx_byte),
		.rx_ready(rx_ready), .tx_byte(tx_byte), .tx_ready(tx_ready), .cmd_start(cmd_start),
		.cmd_letter(cmd_letter), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .can_byte(can_byte),
		.can_ready(can_ready), .can_msg_end(can_msg_end));
	host_link_model i_host_link_model (.clk(clk), .nrst(nrst), .tx_byte(tx_byte), .slow(slow), .tx_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	// The byte is held until the edge that takes it; released data is inverted so it cannot be reused.
	task put_rx(input logic [7:0] b);
		@(posedge clk);
		rx_byte <= '{1'b1, b};
		@(negedge clk);
		while (rx_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		rx_byte <= '{1'b0, ~b};
	endtask : put_rx
	task put_can(input logic [7:0] b, input logic last);
		@(posedge clk);
		can_byte <= '{1'b1, b};
		can_msg_end <= last;
		@(negedge clk);
		while (can_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		can_byte <= '{1'b0, ~b};
		can_msg_end <= 1'b0;
	endtask : put_can
	task run_line(input row_type r);
		int base;
		int starts;
		base = i_host_link_model.got;
		starts = 0;
		put_rx(r.l);
		put_rx(`CHR_CR);
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if (cmd_start === 1'b1) begin
				starts++;
				`CHK(cmd_letter, r.l)
				@(posedge clk);
				cmd_done <= 1'b1;
				cmd_ok <= r.ok;
				@(posedge clk);
				cmd_done <= 1'b0;
			end
		end
		`CHK(starts, int'(r.st))
		`CHK(i_host_link_model.got - base, int'(r.cnt))
		`CHK(i_host_link_model.last_byte, r.last)
	endtask : run_line
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial begin
		int base;
		nrst = 1'b0;
		slow = 1'b0;
		rx_byte = '{1'b0, 8'h00};
		can_byte = '{1'b0, 8'h00};
		can_msg_end = 1'b0;
		cmd_done = 1'b0;
		cmd_ok = 1'b0;
		repeat (2) @(posedge clk);
		`CHK(cmd_start, 1'b0)
		`CHK(rx_ready, 1'b1)
		nrst <= 1'b1;
		foreach (rows[i]) run_line(rows[i]);
		for (int i = 0; i < letters.len(); i++) begin
			@(posedge clk);
			slow <= i[0];
			run_line('{letters[i], 1'b1, `CHR_CR, 8'h01, 1'b1});
		end
		// The help listing must survive a host that stalls every other cycle.
		run_line(rows[6]);
		// A dense burst against a stalling host: every byte must arrive, none lost.
		slow <= 1'b1;
		base = i_host_link_model.got;
		for (int m = 0; m < 100; m++) begin
			put_can(8'(m), 1'b0);
			put_can(8'(m) ^ 8'hFF, 1'b1);
		end
		repeat (4) @(posedge clk);
		`CHK(i_host_link_model.got - base, 200)
		`CHK(i_host_link_model.last_byte, 8'h9C)
		// Host bytes wait while a CAN message owns the link.
		put_can(8'hA5, 1'b0);
		@(negedge clk);
		`CHK(rx_ready, 1'b0)
		put_can(8'h5A, 1'b1);
		@(negedge clk);
		`CHK(rx_ready, 1'b1)
		`CHK(i_host_link_model.last_byte, 8'h5A)
		// A reset in mid-command drops the command and sends no reply.
		base = i_host_link_model.got;
		put_rx(8'h56);
		put_rx(`CHR_CR);
		@(negedge clk);
		`CHK(cmd_start, 1'b1)
		@(posedge clk);
		nrst <= 1'b0;
		@(negedge clk);
		`CHK(rx_ready, 1'b1)
		`CHK(cmd_start, 1'b0)
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(i_host_link_model.got - base, 0)
		run_line(rows[0]);
		stop_test();
	end
endmodule : ascii_can_command_parser_tb_top
